/* File: hdl/ted_pkg.sv */
package ted_pkg;

  // ****************************************************
  // sizes
  // ****************************************************
  localparam int NRING = 4;
  localparam int RING_W = 2;
  localparam int RADDR_W = 8;
  localparam int IDX_W = 16;

  // ****************************************************
  // register offsets (byte addresses)
  // ****************************************************
  localparam logic [7:0] REG_COMMAND_WORD2 = 8'h00;
  localparam logic [7:0] REG_XCTL = 8'h04;
  localparam logic [7:0] REG_IRQ0 = 8'h08;
  localparam logic [7:0] REG_POLL = 8'h0C;
  localparam logic [7:0] REG_RLEN = 8'h10;
  localparam logic [7:0] REG_BASE0 = 8'h20;
  localparam logic [7:0] REG_STEP = 8'h04;

  // ****************************************************
  // register fields and reset values
  // ****************************************************
  localparam int COMMAND_WORD2_APAD_BIT = 6;
  localparam int COMMAND_WORD2_MARKEN_BIT = 9;
  localparam int XCTL_GDIS_BIT = 0;
  localparam int IRQ0_DONE_LSB = 8;
  localparam logic [31:0] COMMAND_WORD2_RST = 32'h0000_0000;
  localparam logic [31:0] XCTL_RST = 32'h0000_0000;
  localparam logic [IDX_W-1:0] RLEN_RST = 16'h0010;
  localparam logic [31:0] BASE_RST = 32'h0000_0000;

  // ****************************************************
  // descriptor layout
  // ****************************************************
  localparam logic [31:0] DESC_W0 = 32'h0000_0000;
  localparam logic [31:0] DESC_W1 = 32'h0000_0004;
  localparam logic [31:0] DESC_W2 = 32'h0000_0008;
  localparam int DESC_SHIFT = 4;
  localparam int D_OWN = 31;
  localparam int D_APPEND = 29;
  localparam int D_MARK = 28;
  localparam int D_HOLD = 26;
  localparam int D_FIRST = 25;
  localparam int D_LAST = 24;
  localparam int D_TCC_LSB = 16;
  localparam logic [1:0] VLAN_KEEP = 2'h0;
  localparam logic [1:0] VLAN_DELETE = 2'h1;
  localparam logic [1:0] VLAN_INSERT = 2'h2;
  localparam logic [1:0] VLAN_REPLACE = 2'h3;

  // ****************************************************
  // types
  // ****************************************************
  typedef enum logic [7:0] {
    ST_IDLE = 8'h01,
    ST_RD0 = 8'h02,
    ST_RD1 = 8'h04,
    ST_RD2 = 8'h08,
    ST_ISSUE = 8'h10,
    ST_WAIT = 8'h20,
    ST_WB = 8'h40,
    ST_WBWAIT = 8'h80
  } ted_state_t;

  typedef struct packed {
    logic [31:0] buf_ptr;
    logic [15:0] byte_count;
    logic [1:0] vlan_tag_command;
    logic [15:0] vlan_tag_info;
    logic first_buffer_flag;
    logic last_buffer_flag;
    logic fcs_enable;
    logic [RING_W-1:0] ring;
  } ted_frame_t;

  typedef struct packed {
    logic we;
    logic [31:0] addr;
    logic [31:0] wdata;
  } ted_mem_t;

  typedef struct packed {
    logic auto_pad_transmit_ctl;
    logic frame_irq_mark_enable;
    logic global_checksum_disable;
    logic [IDX_W-1:0] ring_len;
    logic [NRING-1:0] active;
  } ted_ctl_t;

endpackage

/* File: hdl/ted_arb.sv */
`timescale 1ns/1ps
module ted_arb (
  input wire logic i_ref_clk, // system clock
  input wire logic i_rst_n, // async reset, active low
  input wire logic [ted_pkg::NRING-1:0] i_req, // rings with work
  input wire logic i_hold, // stay on i_hold_ring
  input wire logic [ted_pkg::RING_W-1:0] i_hold_ring, // ring to keep
  input wire logic i_take, // grant consumed this cycle
  output logic o_valid, // a ring may be served
  output logic [ted_pkg::RING_W-1:0] o_grant // chosen ring
);

  logic [ted_pkg::RING_W-1:0] last_reg;
  logic [ted_pkg::RING_W-1:0] last_next;
  logic [ted_pkg::RING_W-1:0] cand;

  // round robin starting after the last served ring
  always_comb begin
    o_valid = 1'b0;
    o_grant = last_reg;
    cand = last_reg;
    if (i_hold) begin
      o_grant = i_hold_ring;
      o_valid = i_req[i_hold_ring];
    end else begin
      for (int k = ted_pkg::NRING; k >= 1; k--) begin
        cand = last_reg + ted_pkg::RING_W'(k);
        if (i_req[cand]) begin
          o_grant = cand;
          o_valid = 1'b1;
        end
      end
    end
    last_next = (i_take && o_valid) ? o_grant : last_reg;
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      last_reg <= '1;
    end else begin
      last_reg <= last_next;
    end
  end

endmodule

/* File: hdl/ted_regs.sv */
`timescale 1ns/1ps
module ted_regs (
  input wire logic i_ref_clk, // system clock
  input wire logic i_rst_n, // async reset, active low
  input wire logic [7:0] i_addr, // register byte address
  input wire logic [31:0] i_wdata, // write data
  input wire logic i_wr, // write strobe
  input wire logic i_rd, // read strobe
  output logic [31:0] o_rdata, // read data, cycle after i_rd
  input wire logic [ted_pkg::NRING-1:0] i_done_set, // done events
  input wire logic [ted_pkg::NRING-1:0] i_stop, // ring found empty
  output ted_pkg::ted_ctl_t o_ctl, // control to engine
  output logic [ted_pkg::NRING-1:0][31:0] o_base // ring bases
);

  logic [31:0] command_word2_reg, command_word2_next;
  logic [31:0] xctl_reg, xctl_next;
  logic [ted_pkg::NRING-1:0] done_reg, done_next;
  logic [ted_pkg::NRING-1:0] act_reg, act_next;
  logic [ted_pkg::IDX_W-1:0] rlen_reg, rlen_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [ted_pkg::NRING-1:0][31:0] base_reg;

  // ****************************************************
  // ring base registers
  // ****************************************************
  for (genvar r = 0; r < ted_pkg::NRING; r++) begin : g_base
    localparam logic [7:0] OFS = ted_pkg::REG_BASE0 +
      8'(r * ted_pkg::REG_STEP);
    logic [31:0] base_next;
    always_comb begin
      base_next = base_reg[r];
      if (i_wr && i_addr == OFS) begin
        base_next = i_wdata;
      end
    end
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
        base_reg[r] <= ted_pkg::BASE_RST;
      end else begin
        base_reg[r] <= base_next;
      end
    end
  end

  // ****************************************************
  // control, status and read port
  // ****************************************************
  always_comb begin
    command_word2_next = command_word2_reg;
    xctl_next = xctl_reg;
    rlen_next = rlen_reg;
    done_next = done_reg;
    act_next = act_reg & ~i_stop;
    rdata_next = 32'h0000_0000;
    if (i_wr) begin
      unique case (i_addr)
        ted_pkg::REG_COMMAND_WORD2: command_word2_next = i_wdata;
        ted_pkg::REG_XCTL: xctl_next = i_wdata;
        ted_pkg::REG_RLEN: rlen_next = i_wdata[ted_pkg::IDX_W-1:0];
        ted_pkg::REG_IRQ0: done_next = done_reg &
          ~i_wdata[ted_pkg::IRQ0_DONE_LSB +: ted_pkg::NRING];
        // a poll demand beats a stop arriving in the same cycle
        ted_pkg::REG_POLL: act_next = act_next | i_wdata[ted_pkg::NRING-1:0];
        default: ;
      endcase
    end
    // event set wins over a write-one clear
    done_next = done_next | i_done_set;
    if (i_rd) begin
      unique case (i_addr)
        ted_pkg::REG_COMMAND_WORD2: rdata_next = command_word2_reg;
        ted_pkg::REG_XCTL: rdata_next = xctl_reg;
        ted_pkg::REG_RLEN: rdata_next = {16'h0000, rlen_reg};
        ted_pkg::REG_IRQ0:
          rdata_next[ted_pkg::IRQ0_DONE_LSB +: ted_pkg::NRING] = done_reg;
        ted_pkg::REG_POLL: rdata_next[ted_pkg::NRING-1:0] = act_reg;
        default: begin
          for (int r = 0; r < ted_pkg::NRING; r++) begin
            if (i_addr == ted_pkg::REG_BASE0 + 8'(r * ted_pkg::REG_STEP)) begin
              rdata_next = base_reg[r];
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      command_word2_reg <= ted_pkg::COMMAND_WORD2_RST;
      xctl_reg <= ted_pkg::XCTL_RST;
      rlen_reg <= ted_pkg::RLEN_RST;
      done_reg <= '0;
      act_reg <= '0;
      rdata_reg <= 32'h0000_0000;
    end else begin
      command_word2_reg <= command_word2_next;
      xctl_reg <= xctl_next;
      rlen_reg <= rlen_next;
      done_reg <= done_next;
      act_reg <= act_next;
      rdata_reg <= rdata_next;
    end
  end

  assign o_rdata = rdata_reg;
  assign o_base = base_reg;
  assign o_ctl.auto_pad_transmit_ctl = command_word2_reg[ted_pkg::COMMAND_WORD2_APAD_BIT];
  assign o_ctl.frame_irq_mark_enable = command_word2_reg[ted_pkg::COMMAND_WORD2_MARKEN_BIT];
  assign o_ctl.global_checksum_disable = xctl_reg[ted_pkg::XCTL_GDIS_BIT];
  assign o_ctl.ring_len = rlen_reg;
  assign o_ctl.active = act_reg;

endmodule

/* File: hdl/ted_tx_desc_engine.sv */
// Functional notes
// - ownership bit 31: 0 host, 1 controller
// - clear ownership bit after buffer transmitted
// - no descriptor edits after handing ownership
// - append flag set forces checksum generation (ignored here while auto padding is on; global disable decides)
// - append flag clear: global disable decides
// - controller never changes append flag
// - unmarked last descriptor raises no done
// - done only when marked and last buffer
// - mark enable off: mark bit ignored
// - priority hold keeps next frame same ring
// - hold continues while each frame sets it
// - hold clear: normal arbitration picks ring
// - hold ignored without first-buffer flag
// - descriptor is four words, fixed layout
// - last flag ends frame; first+last whole
// - pass two-bit VLAN tag command onward
// - send exact byte count, never alter it
//
// Local design decisions: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
module ted_tx_desc_engine (
  input wire logic i_ref_clk, // system clock, 250 MHz
  input wire logic i_rst_n, // async reset, active low
  input wire logic [7:0] i_reg_addr, // register byte address
  input wire logic [31:0] i_reg_wdata, // register write data
  input wire logic i_reg_wr, // register write strobe
  input wire logic i_reg_rd, // register read strobe
  output logic [31:0] o_reg_rdata, // read data, next cycle
  output logic o_mem_req, // memory access request, held
  output ted_pkg::ted_mem_t o_mem, // memory access command
  input wire logic i_mem_ack, // access done, one-cycle pulse
  input wire logic [31:0] i_mem_rdata, // read data with i_mem_ack
  output logic o_frame_valid, // buffer command, one-cycle pulse
  output ted_pkg::ted_frame_t o_frame, // buffer command fields
  input wire logic i_frame_done // buffer copied to transmit fifo
);

  // ****************************************************
  // state
  // ****************************************************
  ted_pkg::ted_state_t state_reg, state_next;
  logic [ted_pkg::RING_W-1:0] ring_reg, ring_next;
  logic [ted_pkg::NRING-1:0][ted_pkg::IDX_W-1:0] idx_reg, idx_next;
  logic [31:0] w0_reg, w0_next;
  logic [31:0] w1_reg, w1_next;
  logic in_frame_reg, in_frame_next;
  logic frame_hold_reg, frame_hold_next;
  logic hold_reg, hold_next;
  logic mem_req_reg, mem_req_next;
  ted_pkg::ted_mem_t mem_reg, mem_next;
  logic fvalid_reg, fvalid_next;
  ted_pkg::ted_frame_t frame_reg, frame_next;
  logic [ted_pkg::NRING-1:0] done_set_reg, done_set_next;
  logic [ted_pkg::NRING-1:0] stop_reg, stop_next;

  ted_pkg::ted_ctl_t ctl;
  logic [ted_pkg::NRING-1:0][31:0] base;
  logic arb_valid;
  logic [ted_pkg::RING_W-1:0] arb_grant;
  logic arb_take;
  logic [31:0] desc_addr;
  logic [ted_pkg::IDX_W-1:0] idx_cur;
  logic [ted_pkg::IDX_W-1:0] idx_adv;
  logic fcs_on;
  logic raise_done;

  // ****************************************************
  // registers and ring arbiter
  // ****************************************************
  ted_regs u_regs (
    .i_ref_clk(i_ref_clk),
    .i_rst_n(i_rst_n),
    .i_addr(i_reg_addr),
    .i_wdata(i_reg_wdata),
    .i_wr(i_reg_wr),
    .i_rd(i_reg_rd),
    .o_rdata(o_reg_rdata),
    .i_done_set(done_set_reg),
    .i_stop(stop_reg),
    .o_ctl(ctl),
    .o_base(base)
  );

  // mid-frame the ring is pinned so chained buffers stay together
  ted_arb u_arb (
    .i_ref_clk(i_ref_clk),
    .i_rst_n(i_rst_n),
    .i_req(ctl.active & ~stop_reg),
    .i_hold(hold_reg | in_frame_reg),
    .i_hold_ring(ring_reg),
    .i_take(arb_take),
    .o_valid(arb_valid),
    .o_grant(arb_grant)
  );

  // ****************************************************
  // helpers
  // ****************************************************
  always_comb begin
    arb_take = (state_reg == ted_pkg::ST_IDLE) && !mem_req_reg;
    idx_cur = idx_reg[ring_reg];
    // wrap at the programmed ring length
    if (idx_cur + 16'h0001 >= ctl.ring_len) begin
      idx_adv = 16'h0000;
    end else begin
      idx_adv = idx_cur + 16'h0001;
    end
    desc_addr = base[arb_grant] +
      32'({idx_reg[arb_grant], 4'h0});
    // auto padding owns the checksum decision, so the flag is ignored
    if (ctl.auto_pad_transmit_ctl) begin
      fcs_on = !ctl.global_checksum_disable;
    end else if (w0_reg[ted_pkg::D_APPEND]) begin
      fcs_on = 1'b1;
    end else begin
      fcs_on = !ctl.global_checksum_disable;
    end
    // mark only matters when enabled and on the last buffer
    raise_done = w0_reg[ted_pkg::D_LAST] &&
      (!ctl.frame_irq_mark_enable ||
       w0_reg[ted_pkg::D_MARK]);
  end

  // ****************************************************
  // descriptor walk
  // ****************************************************
  always_comb begin
    state_next = state_reg;
    ring_next = ring_reg;
    idx_next = idx_reg;
    w0_next = w0_reg;
    w1_next = w1_reg;
    in_frame_next = in_frame_reg;
    frame_hold_next = frame_hold_reg;
    hold_next = hold_reg;
    mem_req_next = mem_req_reg;
    mem_next = mem_reg;
    fvalid_next = 1'b0;
    frame_next = frame_reg;
    done_set_next = '0;
    stop_next = '0;
    unique case (state_reg)
      ted_pkg::ST_IDLE: begin
        if (arb_take && arb_valid) begin
          ring_next = arb_grant;
          mem_req_next = 1'b1;
          mem_next.we = 1'b0;
          mem_next.addr = desc_addr + ted_pkg::DESC_W0;
          state_next = ted_pkg::ST_RD0;
        end
      end
      ted_pkg::ST_RD0: begin
        if (i_mem_ack) begin
          w0_next = i_mem_rdata;
          if (!i_mem_rdata[ted_pkg::D_OWN]) begin
            // host still owns it: park the ring until a poll demand
            mem_req_next = 1'b0;
            stop_next[ring_reg] = 1'b1;
            state_next = ted_pkg::ST_IDLE;
          end else if (!in_frame_reg &&
                       !i_mem_rdata[ted_pkg::D_FIRST]) begin
            // owned but not a frame start: step over, leave untouched
            mem_req_next = 1'b0;
            idx_next[ring_reg] = idx_adv;
            state_next = ted_pkg::ST_IDLE;
          end else begin
            if (!in_frame_reg) begin
              frame_hold_next = i_mem_rdata[ted_pkg::D_HOLD];
            end
            mem_next.addr = mem_reg.addr - ted_pkg::DESC_W0 +
              ted_pkg::DESC_W1;
            state_next = ted_pkg::ST_RD1;
          end
        end
      end
      ted_pkg::ST_RD1: begin
        if (i_mem_ack) begin
          w1_next = i_mem_rdata;
          mem_next.addr = mem_reg.addr - ted_pkg::DESC_W1 +
            ted_pkg::DESC_W2;
          state_next = ted_pkg::ST_RD2;
        end
      end
      ted_pkg::ST_RD2: begin
        if (i_mem_ack) begin
          mem_req_next = 1'b0;
          frame_next.buf_ptr = i_mem_rdata;
          frame_next.byte_count = w0_reg[15:0];
          frame_next.vlan_tag_command =
            w1_reg[ted_pkg::D_TCC_LSB +: 2];
          frame_next.vlan_tag_info = w1_reg[15:0];
          frame_next.first_buffer_flag = w0_reg[ted_pkg::D_FIRST];
          frame_next.last_buffer_flag = w0_reg[ted_pkg::D_LAST];
          frame_next.ring = ring_reg;
          state_next = ted_pkg::ST_ISSUE;
        end
      end
      ted_pkg::ST_ISSUE: begin
        // checksum settings are sampled here for each buffer, so a write mid-frame reaches the later buffers
        frame_next.fcs_enable = fcs_on;
        fvalid_next = 1'b1;
        state_next = ted_pkg::ST_WAIT;
      end
      ted_pkg::ST_WAIT: begin
        if (i_frame_done) begin
          // write back word 0 with only ownership dropped
          mem_req_next = 1'b1;
          mem_next.we = 1'b1;
          mem_next.addr = mem_reg.addr - ted_pkg::DESC_W2 +
            ted_pkg::DESC_W0;
          mem_next.wdata = w0_reg &
            ~(32'h0000_0001 << ted_pkg::D_OWN);
          state_next = ted_pkg::ST_WB;
        end
      end
      ted_pkg::ST_WB: begin
        if (i_mem_ack) begin
          mem_req_next = 1'b0;
          mem_next.we = 1'b0;
          idx_next[ring_reg] = idx_adv;
          if (w0_reg[ted_pkg::D_LAST]) begin
            in_frame_next = 1'b0;
            hold_next = frame_hold_reg;
            done_set_next[ring_reg] = raise_done;
          end else begin
            in_frame_next = 1'b1;
          end
          state_next = ted_pkg::ST_WBWAIT;
        end
      end
      ted_pkg::ST_WBWAIT: begin
        // one idle cycle lets the index and hold updates settle
        state_next = ted_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_reg <= ted_pkg::ST_IDLE;
      ring_reg <= '0;
      idx_reg <= '0;
      w0_reg <= 32'h0000_0000;
      w1_reg <= 32'h0000_0000;
      in_frame_reg <= 1'b0;
      frame_hold_reg <= 1'b0;
      hold_reg <= 1'b0;
      mem_req_reg <= 1'b0;
      mem_reg <= '0;
      fvalid_reg <= 1'b0;
      frame_reg <= '0;
      done_set_reg <= '0;
      stop_reg <= '0;
    end else begin
      state_reg <= state_next;
      ring_reg <= ring_next;
      idx_reg <= idx_next;
      w0_reg <= w0_next;
      w1_reg <= w1_next;
      in_frame_reg <= in_frame_next;
      frame_hold_reg <= frame_hold_next;
      hold_reg <= hold_next;
      mem_req_reg <= mem_req_next;
      mem_reg <= mem_next;
      fvalid_reg <= fvalid_next;
      frame_reg <= frame_next;
      done_set_reg <= done_set_next;
      stop_reg <= stop_next;
    end
  end

  assign o_mem_req = mem_req_reg;
  assign o_mem = mem_reg;
  assign o_frame_valid = fvalid_reg;
  assign o_frame = frame_reg;

endmodule

/* File: testbench/ted_engine_properties.sv */
`timescale 1ns/1ps
module ted_engine_chk (
  input wire logic i_ref_clk, // clock
  input wire logic i_rst_n, // reset, active low
  input wire logic [7:0] i_reg_addr, // register address
  input wire logic [31:0] i_reg_wdata, // register write data
  input wire logic i_reg_wr, // write strobe
  input wire logic i_reg_rd, // read strobe
  input wire logic [31:0] o_reg_rdata, // read data
  input wire logic o_mem_req, // memory request
  input wire ted_pkg::ted_mem_t o_mem, // memory command
  input wire logic i_mem_ack, // memory ack
  input wire logic [31:0] i_mem_rdata, // memory read data
  input wire logic o_frame_valid, // buffer command pulse
  input wire ted_pkg::ted_frame_t o_frame, // buffer command
  input wire logic i_frame_done // buffer copied
);
  // ********************
  // shadow copies
  // ********************
  logic [31:0] w0_reg, w0_next;
  logic apad_reg, apad_next, gdis_reg, gdis_next, fcs_exp;
  always_comb begin
    w0_next = w0_reg;
    apad_next = apad_reg;
    gdis_next = gdis_reg;
    if (o_mem_req && !o_mem.we && i_mem_ack && o_mem.addr[3:0] == 4'h0) begin
      w0_next = i_mem_rdata;
    end
    if (i_reg_wr && i_reg_addr == ted_pkg::REG_COMMAND_WORD2) begin
      apad_next = i_reg_wdata[ted_pkg::COMMAND_WORD2_APAD_BIT];
    end
    if (i_reg_wr && i_reg_addr == ted_pkg::REG_XCTL) begin
      gdis_next = i_reg_wdata[ted_pkg::XCTL_GDIS_BIT];
    end
  end
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      w0_reg <= 32'h0;
      apad_reg <= 1'b0;
      gdis_reg <= 1'b0;
    end else begin
      w0_reg <= w0_next;
      apad_reg <= apad_next;
      gdis_reg <= gdis_next;
    end
  end
  assign fcs_exp = apad_reg ? !gdis_reg
                            : (w0_reg[ted_pkg::D_APPEND] | !gdis_reg);
  // ********************
  // properties
  // ********************
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);
  AST_RDATA_IDLE: assert property (!$past(i_reg_rd) |-> o_reg_rdata == 32'h0)
    else $error("stray read data");
  AST_REQ_HOLD: assert property (o_mem_req && !i_mem_ack |=>
    o_mem_req && $stable(o_mem)) else $error("request not held");
  AST_WB_CLEAR: assert property (o_mem_req && o_mem.we
    |-> o_mem.wdata == (w0_reg & 32'h7FFF_FFFF)) else $error("bad writeback");
  AST_WB_WORD0: assert property (o_mem_req |->
    o_mem.addr[3:0] != 4'hC && (!o_mem.we || o_mem.addr[3:0] == 4'h0))
    else $error("bad access word");
  AST_DONE_WB: assert property (i_frame_done |=>
    o_mem_req && o_mem.we) else $error("no writeback");
  AST_FCS: assert property (o_frame_valid |->
    o_frame.fcs_enable == fcs_exp) else $error("checksum decision wrong");
  AST_FIELDS: assert property (o_frame_valid |->
    o_frame.byte_count == w0_reg[15:0] &&
    o_frame.first_buffer_flag == w0_reg[ted_pkg::D_FIRST] &&
    o_frame.last_buffer_flag == w0_reg[ted_pkg::D_LAST])
    else $error("bad buffer fields");
  AST_NEXT_WORD: assert property (
    o_mem_req && !o_mem.we && i_mem_ack &&
    (o_mem.addr[3:0] == 4'h4 || (o_mem.addr[3:0] == 4'h0 &&
    i_mem_rdata[ted_pkg::D_OWN] && i_mem_rdata[ted_pkg::D_FIRST])) |=>
    o_mem_req && !o_mem.we && o_mem.addr == $past(o_mem.addr) + 32'h4)
    else $error("bad word order");
  AST_ONE_FRAME: assert property (o_frame_valid |=> !o_frame_valid [*3])
    else $error("commands too close");
endmodule
bind ted_tx_desc_engine ted_engine_chk u_chk (.i_ref_clk, .i_rst_n,
  .i_reg_addr, .i_reg_wdata, .i_reg_wr, .i_reg_rd, .o_reg_rdata, .o_mem_req,
  .o_mem, .i_mem_ack, .i_mem_rdata, .o_frame_valid, .o_frame, .i_frame_done);

/* File: testbench/ted_host_mem_model.sv */
`timescale 1ns/1ps
module ted_host_mem_model (
  input wire logic i_ref_clk, // clock
  input wire logic i_rst_n, // reset, active low
  input wire logic i_mem_req, // request from engine
  input wire ted_pkg::ted_mem_t i_mem, // memory command
  output logic o_mem_ack, // completion pulse
  output logic [31:0] o_mem_rdata, // read data with ack
  input wire logic i_frame_valid, // buffer command
  output logic o_frame_done, // buffer copied pulse
  input wire logic [3:0] i_lat // answer delay in cycles
);
  // ********************
  // descriptor memory, filled by the bench
  // ********************
  logic [31:0] mem [64] = '{default: 32'h0};
  logic [3:0] cnt, fcnt;
  logic pend;
  always @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_mem_ack <= 1'b0;
      o_mem_rdata <= 32'h0;
      o_frame_done <= 1'b0;
      cnt <= 4'h0;
      fcnt <= 4'h0;
      pend <= 1'b0;
    end else begin
      o_mem_ack <= 1'b0;
      o_frame_done <= 1'b0;
      // data lines scramble whenever no answer stands
      o_mem_rdata <= ~o_mem_rdata;
      if (i_mem_req && !o_mem_ack) begin
        if (cnt >= i_lat) begin
          o_mem_ack <= 1'b1;
          cnt <= 4'h0;
          if (i_mem.we) begin
            mem[i_mem.addr[7:2]] <= i_mem.wdata;
          end else begin
            o_mem_rdata <= mem[i_mem.addr[7:2]];
          end
        end else begin
          cnt <= cnt + 4'h1;
        end
      end
      if (i_frame_valid) begin
        pend <= 1'b1;
      end else if (pend && fcnt >= i_lat) begin
        pend <= 1'b0;
        fcnt <= 4'h0;
        o_frame_done <= 1'b1;
      end else if (pend) begin
        fcnt <= fcnt + 4'h1;
      end
    end
  end
endmodule

/* File: testbench/eth_tx_descriptor_engine_tb.sv */
`timescale 1ns/1ps
module eth_tx_descriptor_engine_tb;
  logic clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, mem_rdata, v;
  logic mem_req, mem_ack, frame_valid, frame_done;
  logic [3:0] lat = 4'h0;
  ted_pkg::ted_mem_t mem;
  ted_pkg::ted_frame_t frame;
  ted_pkg::ted_frame_t fr [$];
  int n_fail = 0, n_tests = 0;
  always #2 clk = ~clk;
  ted_tx_desc_engine uut (.i_ref_clk(clk), .i_rst_n(rst_n),
    .i_reg_addr(reg_addr), .i_reg_wdata(reg_wdata), .i_reg_wr(reg_wr),
    .i_reg_rd(reg_rd), .o_reg_rdata(reg_rdata), .o_mem_req(mem_req),
    .o_mem(mem), .i_mem_ack(mem_ack), .i_mem_rdata(mem_rdata),
    .o_frame_valid(frame_valid), .o_frame(frame), .i_frame_done(frame_done));
  ted_host_mem_model mdl (.i_ref_clk(clk), .i_rst_n(rst_n),
    .i_mem_req(mem_req), .i_mem(mem), .o_mem_ack(mem_ack),
    .o_mem_rdata(mem_rdata), .i_frame_valid(frame_valid),
    .o_frame_done(frame_done), .i_lat(lat));
  always @(posedge clk) begin
    if (frame_valid === 1'b1) begin
      fr.push_back(frame);
    end
  end
  // ********************
  // tasks
  // ********************
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic chk(input logic [95:0] got, input logic [95:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    rd(a, d);
    chk(d, e);
  endtask
  function automatic logic [31:0] dw(input logic own, app, mark, hold,
                                     first, input logic [7:0] k);
    return {own, 1'b0, app, mark, 1'b0, hold, first, 1'b1, 8'h00,
            16'h0040 + 16'(k)};
  endfunction
  // word 0 goes in last
  task automatic put(input int r, i, input logic [31:0] w0,
                     input logic [7:0] k);
    int b;
    b = r * 8 + i * 4;
    mdl.mem[b+1] = {14'h0, k[1:0], 16'hA000 + 16'(k)};
    mdl.mem[b+2] = 32'h1000_0000 + 32'(k);
    mdl.mem[b+3] = 32'h5555_0000 + 32'(k);
    mdl.mem[b] = w0;
  endtask
  task automatic fchk(input int n, input logic [1:0] r,
                      input logic [7:0] k, input logic f);
    ted_pkg::ted_frame_t e;
    e = '{32'h1000_0000 + 32'(k), 16'h0040 + 16'(k), k[1:0],
          16'hA000 + 16'(k), 1'b1, 1'b1, f, r};
    chk(fr.size() > n ? fr[n] : '0, e);
  endtask
  task automatic run(input int n);
    int t;
    v = 32'hF;
    for (t = 0; t < 1500 && (fr.size() < n || v[3:0] != 4'h0); t++) begin
      rd(ted_pkg::REG_POLL, v);
    end
    if (t == 1500) begin
      n_fail++;
      $display("Error at %0t: rings never idle", $time);
      summarize();
    end
  endtask
  // ********************
  // main sequence
  // ********************
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    rdc(ted_pkg::REG_COMMAND_WORD2, ted_pkg::COMMAND_WORD2_RST);
    rdc(ted_pkg::REG_XCTL, ted_pkg::XCTL_RST);
    rdc(ted_pkg::REG_RLEN, 32'(ted_pkg::RLEN_RST));
    rdc(ted_pkg::REG_IRQ0, 32'h0);
    rdc(ted_pkg::REG_POLL, 32'h0);
    rdc(8'hFC, 32'h0);
    $display("test reset done");
    wr(ted_pkg::REG_RLEN, 32'h2);
    for (int r = 0; r < 4; r++) begin
      wr(8'(ted_pkg::REG_BASE0 + r * ted_pkg::REG_STEP), 32'(r * 32));
    end
    wr(ted_pkg::REG_COMMAND_WORD2, 32'h0000_0200);
    wr(ted_pkg::REG_XCTL, 32'h1);
    put(0, 0, dw(1, 1, 0, 0, 1, 8'd0), 8'd0);
    put(0, 1, 32'h0, 8'd1);
    wr(ted_pkg::REG_POLL, 32'h1);
    run(1);
    rdc(ted_pkg::REG_IRQ0, 32'h0);
    put(0, 1, dw(1, 0, 1, 0, 1, 8'd1), 8'd1);
    wr(ted_pkg::REG_POLL, 32'h1);
    run(2);
    fchk(0, 2'd0, 8'd0, 1'b1);
    fchk(1, 2'd0, 8'd1, 1'b0);
    rdc(ted_pkg::REG_IRQ0, 32'h0000_0100);
    chk(mdl.mem[0], dw(0, 1, 0, 0, 1, 8'd0));
    chk(mdl.mem[3], 32'h5555_0000);
    wr(ted_pkg::REG_IRQ0, 32'h0000_0100);
    rdc(ted_pkg::REG_IRQ0, 32'h0);
    $display("test marking done");
    lat <= 4'h3;
    wr(ted_pkg::REG_COMMAND_WORD2, 32'h0000_0040);
    put(1, 0, dw(1, 1, 0, 0, 1, 8'd2), 8'd2);
    wr(ted_pkg::REG_POLL, 32'h2);
    run(3);
    fchk(2, 2'd1, 8'd2, 1'b0);
    rdc(ted_pkg::REG_IRQ0, 32'h0000_0200);
    $display("test auto padding done");
    lat <= 4'h1;
    wr(ted_pkg::REG_COMMAND_WORD2, 32'h0);
    wr(ted_pkg::REG_XCTL, 32'h0);
    put(2, 0, dw(1, 0, 0, 1, 1, 8'd3), 8'd3);
    put(2, 1, dw(1, 0, 0, 0, 1, 8'd4), 8'd4);
    put(3, 0, dw(1, 0, 0, 0, 1, 8'd5), 8'd5);
    put(3, 1, dw(1, 0, 0, 1, 0, 8'd6), 8'd6);
    wr(ted_pkg::REG_POLL, 32'hC);
    run(6);
    fchk(3, 2'd2, 8'd3, 1'b1);
    fchk(4, 2'd2, 8'd4, 1'b1);
    fchk(5, 2'd3, 8'd5, 1'b1);
    chk(fr.size(), 6);
    chk(mdl.mem[28], dw(1, 0, 0, 1, 0, 8'd6));
    $display("test priority hold done");
    summarize();
  end
endmodule
